// ==== rtl/psc_pkg.sv ====
// Constants and types shared by the PCM slot codec port
//------------------------------------------------------------------------
// Overview of operation
// - Transmit latches one 8-bit coded sample per frame into its slot
// - Each channel has its own transmit sync marking its slot
// - Buffer-enable is low exactly while the data pin is driven
// - Receive captures one 8-bit sample per frame under its own sync
// - G.711 A-law or u-law coding; A-law bytes get alternate inversion
// - Law select low picks u-law, high picks A-law
// - Sync spanning one or two clock falls means short mode
// - Short mode: first rise after slot start drives sign bit, enable low
// - Short mode: seven more rises shift, eighth fall releases the pin
// - Latter part of every bit period is held only weakly
// - First fall after receive slot start latches sign, seven more follow
// - Sync spanning three or more falls means long mode
// - Long mode: sign bit driven at slot start, seven rises shift
// - Long mode: release at later of eighth fall and sync end
// - Long sync past eighth edge keeps eighth bit on the pin
// - Transmit gain code selects one of three reference currents
// - Balance bit selects one of two balance network inputs
// - Receive gain code selects one of three reference voltages
// - Receive code 00 unity, 01 second, 10 third, 11 unused
// - Transmit decimator drops the converter rate to 16 kHz
// - Transmit filters reject mains hum and band-limit to 3400 Hz
// - Receive path interpolates up after expansion and low-pass
// - Own buffer-enable lets several devices share one highway
//------------------------------------------------------------------------
`default_nettype none
package psc_pkg;
  localparam int          NUM_CH      = 4;
  localparam int          CODE_W      = 8;
  localparam int          LIN_W       = 14;
  localparam int          ACC_W       = 16;
  localparam int          FRAME_US    = 125;
  localparam logic [1:0]  LONG_EDGES  = 2'h3;
  localparam logic [2:0]  SLOT_LAST   = 3'h7;
  localparam logic [2:0]  SHIFT_LAST  = 3'h7;
  localparam int          CORE_HZ     = 125_000_000;
  localparam int          DEC_HZ      = 16_000;
  localparam int          DEC_RATIO   = 8;
  localparam int          OS_DIV_DEF  = CORE_HZ / (DEC_HZ * DEC_RATIO);
  localparam int          BCLK_MIN_HZ = 256_000;
  localparam int          BCLK_MAX_HZ = 4_096_000;
  localparam int          HIGHPASS_SHIFT = 8;
  localparam int          LOWPASS_SHIFT  = 2;
  localparam int          INTERP_SHIFT = 3;
  localparam logic [13:0] MAG_BIAS    = 14'h0021;
  localparam logic [13:0] ULAW_CLIP   = 14'h1FDE;
  localparam logic [13:0] ALAW_CLIP   = 14'h0FFF;
  localparam logic [13:0] ALAW_SEG0   = 14'h0020;
  localparam logic [7:0]  ALAW_ABI    = 8'h55;
  localparam logic [1:0]  GAIN_SEL1   = 2'h0;
  localparam logic [1:0]  GAIN_SEL2   = 2'h1;
  localparam logic [1:0]  GAIN_SEL3   = 2'h2;
  localparam logic [1:0]  GAIN_BAD    = 2'h3;
  localparam logic [2:0]  REF_SEL_RST = 3'h1;
  // Avalon map: one control word per channel, then status
  localparam int          ADDR_W      = 5;
  localparam int          CTRL_W      = 5;
  localparam logic [4:0]  CTRL_RST    = 5'h00;
  localparam logic [2:0]  STATUS_WORD = 3'h4;
  localparam int          BAL_BIT     = 0;
  localparam int          RGS_LO_BIT  = 1;
  localparam int          TGS_LO_BIT  = 2;
  localparam int          RGS_HI_BIT  = 3;
  localparam int          TGS_HI_BIT  = 4;
  localparam int          STAT_LAW_BIT = 8;

  typedef enum {TX_IDLE, TX_WAIT, TX_DRIVE, TX_HOLD} psc_tx_state_t;
  typedef enum {RX_IDLE, RX_SHIFT} psc_rx_state_t;
endpackage : psc_pkg
`default_nettype wire

// ==== rtl/psc_law_if.sv ====
// Interface between the slot logic and the companding coder
`timescale 1ns/1ns
`default_nettype none
interface psc_law_if;
  logic              alaw;
  logic signed [13:0] lin_tx;
  logic [7:0]        code_tx;
  logic [7:0]        code_rx;
  logic signed [13:0] lin_rx;
  modport coder (input alaw, lin_tx, code_rx, output code_tx, lin_rx);
  modport user  (output alaw, lin_tx, code_rx, input code_tx, lin_rx);
endinterface : psc_law_if
`default_nettype wire

// ==== rtl/psc_sync.sv ====
// Two-stage synchroniser for pins and the reset release
`timescale 1ns/1ns
`default_nettype none
module psc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : psc_sync
`default_nettype wire

// ==== rtl/psc_law.sv ====
// G.711 compressor and expander for one channel
`timescale 1ns/1ns
`default_nettype none
module psc_law (
  psc_law_if.coder lw
);
  import psc_pkg::*;

  function automatic logic [2:0] top_seg(input logic [13:0] m,
                                         input int         base);
    logic [2:0] s;
    s = 3'h0;
    for (int i = 0; i < 8; i++)
      if (m[base + i])
        s = 3'(i);
    return s;
  endfunction : top_seg

  function automatic logic [7:0] ulaw_enc(input logic signed [13:0] x);
    logic        neg;
    logic [13:0] mag;
    logic [2:0]  seg;
    logic [3:0]  man;
    neg = x[13];
    mag = neg ? 14'(-x) : 14'(x);
    if (mag > ULAW_CLIP)
      mag = ULAW_CLIP;
    mag = mag + MAG_BIAS;
    seg = top_seg(mag, 5);
    man = 4'(mag >> ({1'b0, seg} + 4'h1));
    return ~{neg, seg, man};
  endfunction : ulaw_enc

  function automatic logic [7:0] alaw_enc(input logic signed [13:0] x);
    logic        neg;
    logic [13:0] mag;
    logic [2:0]  seg;
    logic [3:0]  man;
    neg = x[13];
    mag = neg ? 14'(-x) : 14'(x);
    mag = mag >> 1;
    if (mag > ALAW_CLIP)
      mag = ALAW_CLIP;
    seg = (mag < ALAW_SEG0) ? 3'h0 : top_seg(mag, 4);
    man = (seg == 3'h0) ? 4'(mag >> 1) : 4'(mag >> seg);
    return {~neg, seg, man} ^ ALAW_ABI;
  endfunction : alaw_enc

  function automatic logic signed [13:0] ulaw_dec(input logic [7:0] code);
    logic [7:0]  c;
    logic [13:0] mag;
    c   = ~code;
    mag = ((14'({c[3:0], 1'b0}) + MAG_BIAS) << c[6:4]) - MAG_BIAS;
    return c[7] ? 14'(-mag) : 14'(mag);
  endfunction : ulaw_dec

  function automatic logic signed [13:0] alaw_dec(input logic [7:0] code);
    logic [7:0]  c;
    logic [13:0] mag;
    c = code ^ ALAW_ABI;
    if (c[6:4] == 3'h0)
      mag = 14'({c[3:0], 1'b1});
    else
      mag = (14'({c[3:0], 1'b0}) + MAG_BIAS) << (c[6:4] - 3'h1);
    mag = mag << 1;
    return c[7] ? 14'(mag) : 14'(-mag);
  endfunction : alaw_dec

  assign lw.code_tx = lw.alaw ? alaw_enc(lw.lin_tx) : ulaw_enc(lw.lin_tx);
  assign lw.lin_rx  = lw.alaw ? alaw_dec(lw.code_rx) : ulaw_dec(lw.code_rx);
endmodule : psc_law
`default_nettype wire

// ==== rtl/pcm_slot_codec_port.sv ====
// Four-channel PCM highway time-slot port with companding and filters
`timescale 1ns/1ns
`default_nettype none
module pcm_slot_codec_port #(
  parameter int NCH    = psc_pkg::NUM_CH,
  parameter int OS_DIV = psc_pkg::OS_DIV_DEF
) (
  input  wire logic                          core_clk,
  input  wire logic                          resetn,
  input  wire logic                          pcm_clk,
  input  wire logic [NCH-1:0]                tx_slot_sync,
  input  wire logic [NCH-1:0]                rx_slot_sync,
  input  wire logic                          pcm_rx_in,
  input  wire logic                          law_sel_alaw,
  input  wire logic [NCH-1:0][psc_pkg::LIN_W-1:0] tx_adc_in,
  output var  logic                          pcm_tx_out,
  output var  logic                          pcm_tx_oe_n,
  output var  logic                          pcm_tx_weak,
  output var  logic                          tx_buffer_enable_n,
  output var  logic [NCH-1:0][2:0]           tx_ref_sel,
  output var  logic [NCH-1:0][2:0]           rx_ref_sel,
  output var  logic [NCH-1:0]                bal_in_sel,
  output logic      [NCH-1:0][psc_pkg::LIN_W-1:0] rx_dac_out,
  input  wire logic [psc_pkg::ADDR_W-1:0]    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output var  logic [31:0]                   avs_readdata,
  output logic                               avs_waitrequest
);
  import psc_pkg::*;

  localparam int PIN_W = 3 + 2 * NCH;
  localparam int OS_W  = $clog2(OS_DIV);

  //----------------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------------
  function automatic logic [2:0] ref_onehot(input logic [1:0] code);
    logic [2:0] r;
    case (code)
      GAIN_SEL1: r = 3'h1;
      GAIN_SEL2: r = 3'h2;
      GAIN_SEL3: r = 3'h4;
      default:   r = REF_SEL_RST;
    endcase
    return r;
  endfunction : ref_onehot

  function automatic logic signed [ACC_W-1:0] ext(
    input logic signed [LIN_W-1:0] x);
    return ACC_W'(x);
  endfunction : ext

  function automatic logic signed [LIN_W-1:0] sat(
    input logic signed [ACC_W-1:0] x);
    logic signed [LIN_W-1:0] r;
    if (x > ACC_W'(14'sh1FFF))
      r = 14'sh1FFF;
    else if (x < -ACC_W'(16'sh2000))
      r = -14'sh2000;
    else
      r = LIN_W'(x);
    return r;
  endfunction : sat

  //----------------------------------------------------------------------
  // Reset release and pin synchronisers
  //----------------------------------------------------------------------
  logic             rst_n;
  logic [PIN_W-1:0] pins_s;
  logic             clk_s;
  logic             clk_d;
  logic [NCH-1:0]   fs_tx_s;
  logic [NCH-1:0]   fs_rx_s;
  logic             din_s;
  logic             law_s;

  psc_sync #(.W(1)) u_rst (
    .clk   (core_clk),
    .rst_n (resetn),
    .d     (1'b1),
    .q     (rst_n)
  );

  psc_sync #(.W(PIN_W)) u_pins (
    .clk   (core_clk),
    .rst_n (rst_n),
    .d     ({law_sel_alaw, pcm_rx_in, rx_slot_sync, tx_slot_sync, pcm_clk}),
    .q     (pins_s)
  );

  assign {law_s, din_s, fs_rx_s, fs_tx_s, clk_s} = pins_s;

  // 125 MHz sampling gives 15 samples per half period at 4.096 MHz
  wire clk_rise = clk_s && !clk_d;
  wire clk_fall = !clk_s && clk_d;

  //----------------------------------------------------------------------
  // Rate dividers
  //----------------------------------------------------------------------
  logic [OS_W-1:0] os_cnt;
  logic [2:0]      dec_cnt;
  wire os_en  = (os_cnt == OS_W'(OS_DIV - 1));
  wire dec_en = os_en && (dec_cnt == 3'(DEC_RATIO - 1));

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_d   <= 1'b0;
      os_cnt  <= '0;
      dec_cnt <= '0;
    end
    else
    begin
      clk_d   <= clk_s;
      os_cnt  <= os_en ? '0 : os_cnt + OS_W'(1);
      if (os_en)
        dec_cnt <= dec_cnt + 3'h1;
    end
  end

  //----------------------------------------------------------------------
  // Avalon control and status
  //----------------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl [NCH];
  logic              bus_ack;
  logic [NCH-1:0]    mode_long_v;
  wire  [2:0]        word     = avs_address[ADDR_W-1:2];
  wire               hit_ctrl = (32'(word) < NCH);
  wire               hit_stat = (word == STATUS_WORD);
  wire  [31:0]       stat_val = 32'({law_s, 8'(mode_long_v)});
  wire  [31:0]       rd_val   = hit_ctrl ? 32'(ctrl[word[1:0]]) :
                                hit_stat ? stat_val : 32'h0000_0000;

  assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_ack      <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      for (int i = 0; i < NCH; i++)
        ctrl[i] <= CTRL_RST;
    end
    else
    begin
      bus_ack <= (avs_read || avs_write) && !bus_ack;
      if (avs_read && !bus_ack)
        avs_readdata <= rd_val;
      if (avs_write && bus_ack && hit_ctrl && avs_byteenable[0])
        ctrl[word[1:0]] <= avs_writedata[CTRL_W-1:0];
    end
  end

  //----------------------------------------------------------------------
  // Per-channel slot timing and signal path
  //----------------------------------------------------------------------
  logic [NCH-1:0] tx_drive;
  logic [NCH-1:0] tx_bit;

  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    psc_tx_state_t       tx_state;
    psc_rx_state_t       rx_state;
    logic [1:0]          fe_cnt;
    logic                mode_long;
    logic                fs_tx_d;
    logic                tx_started;
    logic                rx_started;
    logic [2:0]          rise_cnt;
    logic [2:0]          tx_fall_cnt;
    logic [2:0]          rx_cnt;
    logic [7:0]          tx_sh;
    logic [7:0]          rx_sh;
    logic [7:0]          rx_code;
    logic [ACC_W+2:0]    dec_sum;
    logic signed [ACC_W-1:0] dec_x;
    logic signed [ACC_W-1:0] hp_avg;
    logic signed [ACC_W-1:0] hp_y;
    logic signed [ACC_W-1:0] lp_tx;
    logic signed [ACC_W-1:0] rx_lp;
    logic signed [ACC_W-1:0] dac;
    logic                dec_rdy;
    logic                hp_rdy;
    psc_law_if           lw ();

    wire tx_fs       = fs_tx_s[c];
    wire rx_fs       = fs_rx_s[c];
    wire tx_go_short = !mode_long && tx_fs && clk_fall && !tx_started;
    wire tx_go_long  = mode_long && tx_fs && clk_s && !tx_started;
    wire rx_go       = rx_fs && !rx_started &&
                       (mode_long ? clk_s : clk_fall);
    wire [1:0] tx_gsel = {ctrl[c][TGS_HI_BIT], ctrl[c][TGS_LO_BIT]};
    wire [1:0] rx_gsel = {ctrl[c][RGS_HI_BIT], ctrl[c][RGS_LO_BIT]};
    wire signed [ACC_W+2:0] x_ext = (ACC_W+3)'(signed'(tx_adc_in[c]));

    assign lw.alaw   = law_s;
    assign lw.lin_tx = sat(lp_tx);
    assign lw.code_rx = rx_code;
    assign tx_drive[c] = (tx_state == TX_DRIVE) || (tx_state == TX_HOLD);
    assign tx_bit[c]   = tx_sh[7];
    assign mode_long_v[c] = mode_long;
    assign rx_dac_out[c]  = LIN_W'(dac);

    psc_law u_law (
      .lw (lw)
    );

    // Mode only takes effect from the next frame, so frame one runs short
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        fe_cnt    <= '0;
        mode_long <= 1'b0;
        fs_tx_d   <= 1'b0;
      end
      else
      begin
        fs_tx_d <= tx_fs;
        if (tx_fs && clk_fall && fe_cnt != LONG_EDGES)
          fe_cnt <= fe_cnt + 2'h1;
        else if (!tx_fs && fs_tx_d)
        begin
          mode_long <= (fe_cnt == LONG_EDGES);
          fe_cnt    <= '0;
        end
      end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        tx_state    <= TX_IDLE;
        tx_started  <= 1'b0;
        tx_sh       <= '0;
        rise_cnt    <= '0;
        tx_fall_cnt <= '0;
      end
      else
      begin
        if (!tx_fs)
          tx_started <= 1'b0;
        case (tx_state)
          TX_IDLE:
            if (tx_go_short || tx_go_long)
            begin
              tx_started  <= 1'b1;
              tx_sh       <= lw.code_tx;
              rise_cnt    <= '0;
              tx_fall_cnt <= '0;
              tx_state    <= tx_go_long ? TX_DRIVE : TX_WAIT;
            end
          TX_WAIT:
            if (clk_rise)
              tx_state <= TX_DRIVE;
          TX_DRIVE:
          begin
            if (clk_rise && rise_cnt != SHIFT_LAST)
            begin
              tx_sh    <= {tx_sh[6:0], 1'b0};
              rise_cnt <= rise_cnt + 3'h1;
            end
            if (clk_fall)
            begin
              tx_fall_cnt <= tx_fall_cnt + 3'h1;
              if (tx_fall_cnt == SLOT_LAST)
                tx_state <= (mode_long && tx_fs) ? TX_HOLD : TX_IDLE;
            end
          end
          TX_HOLD:
            if (!tx_fs)
              tx_state <= TX_IDLE;
          default:
            tx_state <= TX_IDLE;
        endcase
      end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        rx_state   <= RX_IDLE;
        rx_started <= 1'b0;
        rx_cnt     <= '0;
        rx_sh      <= '0;
        rx_code    <= '0;
      end
      else
      begin
        if (!rx_fs)
          rx_started <= 1'b0;
        case (rx_state)
          RX_IDLE:
            if (rx_go)
            begin
              rx_started <= 1'b1;
              rx_cnt     <= '0;
              rx_state   <= RX_SHIFT;
            end
          RX_SHIFT:
            if (clk_fall)
            begin
              rx_sh  <= {rx_sh[6:0], din_s};
              rx_cnt <= rx_cnt + 3'h1;
              if (rx_cnt == SLOT_LAST)
              begin
                rx_code  <= {rx_sh[6:0], din_s};
                rx_state <= RX_IDLE;
              end
            end
          default:
            rx_state <= RX_IDLE;
        endcase
      end
    end

    // One-pole sections; cheap, but hum and band edges are not sharp
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        dec_sum <= '0;
        dec_x   <= '0;
        dec_rdy <= 1'b0;
        hp_avg  <= '0;
        hp_y    <= '0;
        hp_rdy  <= 1'b0;
        lp_tx   <= '0;
        rx_lp   <= '0;
        dac     <= '0;
      end
      else
      begin
        dec_rdy <= dec_en;
        hp_rdy  <= dec_rdy;
        if (dec_en)
        begin
          dec_x   <= ACC_W'((signed'(dec_sum) + x_ext) >>> 3);
          dec_sum <= '0;
        end
        else if (os_en)
          dec_sum <= dec_sum + x_ext;
        if (dec_rdy)
        begin
          hp_avg <= hp_avg + ((dec_x - hp_avg) >>> HIGHPASS_SHIFT);
          hp_y   <= dec_x - hp_avg;
        end
        if (hp_rdy)
          lp_tx <= lp_tx + ((hp_y - lp_tx) >>> LOWPASS_SHIFT);
        if (dec_en)
          rx_lp <= rx_lp + ((ext(lw.lin_rx) - rx_lp) >>> LOWPASS_SHIFT);
        if (os_en)
          dac <= dac + ((rx_lp - dac) >>> INTERP_SHIFT);
      end
    end

    // Code 11 is not allowed; the last legal selection is kept
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        tx_ref_sel[c] <= REF_SEL_RST;
        rx_ref_sel[c] <= REF_SEL_RST;
        bal_in_sel[c] <= 1'b0;
      end
      else
      begin
        if (tx_gsel != GAIN_BAD)
          tx_ref_sel[c] <= ref_onehot(tx_gsel);
        if (rx_gsel != GAIN_BAD)
          rx_ref_sel[c] <= ref_onehot(rx_gsel);
        bal_in_sel[c] <= ctrl[c][BAL_BIT];
      end
    end
  end

  //----------------------------------------------------------------------
  // Shared highway pin and buffer control
  //----------------------------------------------------------------------
  wire any_drive = |tx_drive;
  wire sel_bit   = |(tx_drive & tx_bit);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pcm_tx_out         <= 1'b0;
      pcm_tx_oe_n        <= 1'b1;
      pcm_tx_weak        <= 1'b0;
      tx_buffer_enable_n <= 1'b1;
    end
    else
    begin
      pcm_tx_out         <= sel_bit;
      pcm_tx_oe_n        <= !any_drive;
      pcm_tx_weak        <= any_drive && !clk_s;
      tx_buffer_enable_n <= !any_drive;
    end
  end
endmodule : pcm_slot_codec_port
`default_nettype wire

// ==== sim/psc_port_checker.sv ====
// Concurrent checks on the slot port pins and register handshake
`timescale 1ns/1ns
`default_nettype none
module psc_port_checker #(
  parameter int NCH = 4
) (
  input wire logic                core_clk,
  input wire logic                resetn,
  input wire logic                pcm_tx_oe_n,
  input wire logic                pcm_tx_weak,
  input wire logic                tx_buffer_enable_n,
  input wire logic [NCH-1:0][2:0] tx_ref_sel,
  input wire logic [NCH-1:0][2:0] rx_ref_sel,
  input wire logic [NCH-1:0]      bal_in_sel,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic                avs_waitrequest
);
  logic [7:0]     low_cnt;
  logic [NCH-1:0] t_hot;
  logic [NCH-1:0] r_hot;
  // Counter, since a slot is far longer than a repetition may be
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      low_cnt <= 8'h00;
    else
      low_cnt <= pcm_tx_oe_n ? 8'h00 : low_cnt + 8'h01;
  always_comb
    for (int i = 0; i < NCH; i++)
    begin
      t_hot[i] = $onehot(tx_ref_sel[i]);
      r_hot[i] = $onehot(rx_ref_sel[i]);
    end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  property p_buf_eq;
    tx_buffer_enable_n == pcm_tx_oe_n;
  endproperty
  a_buf_eq: assert property (p_buf_eq)
    else $error("buffer enable differs from pin enable");
  property p_weak_drv;
    pcm_tx_weak |-> !pcm_tx_oe_n;
  endproperty
  a_weak_drv: assert property (p_weak_drv)
    else $error("weak hold while pin released");
  property p_start_strong;
    $fell(pcm_tx_oe_n) |-> !pcm_tx_weak [*2];
  endproperty
  a_start_strong: assert property (p_start_strong)
    else $error("slot starts weakly driven");
  property p_slot_len;
    $rose(pcm_tx_oe_n) |-> low_cnt inside {[8'h46:8'h50]};
  endproperty
  a_slot_len: assert property (p_slot_len)
    else $error("slot drive length wrong");
  property p_tx_hot;
    &t_hot;
  endproperty
  a_tx_hot: assert property (p_tx_hot)
    else $error("transmit reference not one-hot");
  property p_rx_hot;
    &r_hot;
  endproperty
  a_rx_hot: assert property (p_rx_hot)
    else $error("receive reference not one-hot");
  property p_bal_hold;
    !avs_write [*3] |-> $stable(bal_in_sel);
  endproperty
  a_bal_hold: assert property (p_bal_hold)
    else $error("balance select moved without write");
  property p_wait;
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait)
    else $error("read answer late");
endmodule : psc_port_checker
bind pcm_slot_codec_port psc_port_checker #(.NCH(NCH)) u_chk (
  .core_clk, .resetn, .pcm_tx_oe_n, .pcm_tx_weak, .tx_buffer_enable_n,
  .tx_ref_sel, .rx_ref_sel, .bal_in_sel, .avs_read, .avs_write,
  .avs_waitrequest
);
`default_nettype wire

// ==== sim/psc_hwy_model.sv ====
// Highway controller model: bit clock, slot syncs, receive data
`timescale 1ns/1ns
`default_nettype none
module psc_hwy_model #(
  parameter int NCH = 4
) (
  output var logic           pcm_clk,
  output var logic [NCH-1:0] tx_slot_sync,
  output var logic [NCH-1:0] rx_slot_sync,
  output var logic           pcm_rx_in,
  input wire logic           pcm_tx_out,
  input wire logic           pcm_tx_oe_n
);
  logic [7:0] txc = 8'h00;
  initial
  begin
    pcm_clk = 0;
    tx_slot_sync = '0;
    rx_slot_sync = '0;
    pcm_rx_in = 0;
  end
  // Clock stands still between frames; one sync pulse per frame
  task automatic frame(input int ch, input bit lng, input logic [7:0] rc);
    int i;
    tx_slot_sync[ch] = lng;
    rx_slot_sync[ch] = lng;
    // Even offset keeps pin edges clear of core clock edges
    #42;
    for (int r = 0; r < 10; r++)
    begin
      i = r - (lng ? 0 : 1);
      pcm_clk = 1;
      pcm_rx_in = (i >= 0 && i < 8) ? rc[7-i] : ~pcm_rx_in;
      if (r == (lng ? 3 : 1))
      begin
        tx_slot_sync[ch] = 0;
        rx_slot_sync[ch] = 0;
      end
      #20;
      if (!lng && r == 0)
      begin
        tx_slot_sync[ch] = 1;
        rx_slot_sync[ch] = 1;
      end
      #20;
      if (i >= 0 && i < 8)
        txc[7-i] = pcm_tx_oe_n ? 1'hx : pcm_tx_out;
      pcm_clk = 0;
      #40;
    end
    #158;
  endtask : frame
endmodule : psc_hwy_model
`default_nettype wire

// ==== sim/pcm_slot_codec_port_test.sv ====
// Self-checking bench for the PCM slot codec port
`timescale 1ns/1ns
`default_nettype none
module pcm_slot_codec_port_test;
  import psc_pkg::*;
  localparam int N = 4;
  logic core_clk = 0;
  logic resetn = 0;
  logic law_sel_alaw = 0;
  logic pcm_clk, pcm_rx_in, pcm_tx_out, pcm_tx_oe_n;
  logic pcm_tx_weak, tx_buffer_enable_n, avs_waitrequest;
  logic [N-1:0] tx_slot_sync, rx_slot_sync, bal_in_sel;
  logic [N-1:0][2:0] tx_ref_sel, rx_ref_sel;
  logic [N-1:0][LIN_W-1:0] tx_adc_in = '0;
  logic [N-1:0][LIN_W-1:0] rx_dac_out;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, got;
  int errors = 0;
  int tests_run = 0;
  pcm_slot_codec_port #(.NCH(N), .OS_DIV(16)) dut (
    .core_clk, .resetn, .pcm_clk, .tx_slot_sync, .rx_slot_sync, .pcm_rx_in,
    .law_sel_alaw, .tx_adc_in, .pcm_tx_out, .pcm_tx_oe_n, .pcm_tx_weak,
    .tx_buffer_enable_n, .tx_ref_sel, .rx_ref_sel, .bal_in_sel, .rx_dac_out,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest
  );
  psc_hwy_model #(.NCH(N)) hwy (
    .pcm_clk, .tx_slot_sync, .rx_slot_sync, .pcm_rx_in, .pcm_tx_out,
    .pcm_tx_oe_n
  );
  always #4 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask : chk
  task automatic conclude;
    if (errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // Holds the request until an edge that sees waitrequest low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0)
    begin
      n++;
      if (n > 50)
      begin
        errors++;
        conclude();
      end
      @(posedge core_clk);
    end
    got = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
  endtask : bus
  initial
  begin
    logic [4:0] v;
    int k;
    repeat (10) @(posedge core_clk);
    resetn <= 1;
    repeat (6) @(posedge core_clk);
    chk("tx_ref", {N{3'h1}}, tx_ref_sel);
    for (int c = 0; c < N; c++)
      for (int g = 0; g < 4; g++)
      begin
        v = {g[1], g[1], g[0], g[0], g[0]};
        k = (g == 3) ? 2 : g;
        bus(1, 5'(4 * c), 32'(v));
        bus(0, 5'(4 * c), 0);
        chk("ctrl", 32'(v), got);
        repeat (3) @(posedge core_clk);
        chk("tx_ref", 3'h1 << k, tx_ref_sel[c]);
        chk("rx_ref", 3'h1 << k, rx_ref_sel[c]);
        chk("bal", g[0], bal_in_sel[c]);
      end
    bus(1, 5'h14, 32'hFFFFFFFF);
    bus(0, 5'h14, 0);
    chk("unmapped", 0, got);
    for (int l = 0; l < 2; l++)
    begin
      law_sel_alaw <= l[0];
      for (int m = 0; m < 2; m++)
      begin
        // Mode is learnt from the frame before, so the last one counts
        repeat (3) hwy.frame(1, m[0], m[0] ? 8'h00 : 8'h80);
        chk("tx_byte", l ? 8'hD5 : 8'hFF, hwy.txc);
        // Receive filters need several output periods to swing sign
        repeat (1000) @(posedge core_clk);
        chk("rx_sign", m[0], rx_dac_out[1][LIN_W-1]);
        bus(0, 5'h10, 0);
        chk("status", {l[0], 6'h0, m[0], 1'h0}, got[8:0]);
      end
    end
    conclude();
  end
endmodule : pcm_slot_codec_port_test
`default_nettype wire
